// *** shared/drive_ctl_pkg.sv ***
`default_nettype none
package drive_ctl_pkg;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int          NUM_SELECTS   = 4;
    localparam int          HEAD_BITS     = 2;
    localparam logic [1:0]  SELECT_ID_RST = 2'h0;   // default drive address
    localparam logic        LINE_TRUE     = 1'h0;   // low level is true
    localparam logic        LINE_FALSE    = 1'h1;   // high or open is false
    localparam logic [1:0]  HEAD_RST      = 2'h0;

    // step edge detector states
    typedef enum logic [0:0] {
        STEP_IDLE = 1'h0,
        STEP_HIGH = 1'h1
    } step_state_t;

endpackage
`default_nettype wire

// *** src/disk_drive_control_select.sv ***
// Contract
// - accept shared inputs only when own select true
// - gate reduced current, write gate, heads, step, direction
// - write data only while write gate low
// - write gate inactive means read data flows
// - step only moves actuator while not writing
// - all control inputs are active low
// - unselected drive ignores inputs, outputs open
// - two head lines give head 0 to 3
// - movement starts on step trailing edge
// - direction false outward, true inward
`timescale 1ns/1ns
`default_nettype none

module disk_drive_control_select
    import drive_ctl_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire logic [1:0]             select_id,
    input  wire logic [NUM_SELECTS-1:0] drive_sel_n,
    input  wire logic                   reduced_wc_n,
    input  wire logic                   write_gate_n,
    input  wire logic [HEAD_BITS-1:0]   head_sel_n,
    input  wire logic                   step_n,
    input  wire logic                   dir_in_n,
    input  wire logic                   write_data,
    input  wire logic                   read_data,
    input  wire logic                   status_n,
    output logic                        selected,
    output logic                        write_enable,
    output logic                        reduced_current,
    output logic [HEAD_BITS-1:0]        head_num,
    output logic                        step_pulse,
    output logic                        step_inward,
    output logic                        disk_write_data,
    output logic                        read_data_out,
    output logic                        read_data_oe_n,
    output logic                        status_out_n,
    output logic                        status_oe_n,
    output logic                        drive_selected_n,
    output logic                        drive_selected_oe_n
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the address strap is two bits and the head decode is a plain
    // inversion of two lines; other sizes would alias drives or heads
    if (NUM_SELECTS != 4) begin : g_bad_selects
        $error("drive select decode needs exactly four lines");
    end
    if (HEAD_BITS != 2) begin : g_bad_heads
        $error("head decode needs exactly two lines");
    end

    // ------------------------------------------------------------
    // select decode and input gating
    // ------------------------------------------------------------
    logic        sel_now;
    logic        wg_true;
    logic [1:0]  id_r;
    logic        sel_r;
    step_state_t step_st_r;
    step_state_t step_st_nxt;

    // drive address reloaded from the strap whenever the bus is idle and this drive was not selected last cycle
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            id_r <= SELECT_ID_RST;
        end else if (!sel_r && drive_sel_n == {NUM_SELECTS{LINE_FALSE}}) begin
            id_r <= select_id;  // only reloaded while bus is idle
        end
    end

    // every host control input passes through sel_now, so a deselected
    // drive cannot see write gate, step or head lines at all
    assign sel_now = (drive_sel_n[id_r] == LINE_TRUE);
    assign wg_true = sel_now && (write_gate_n == LINE_TRUE);

    // ------------------------------------------------------------
    // registered control outputs, one process per concern
    // ------------------------------------------------------------
    // select seen last cycle; feeds the idle checks and the address
    // reload guard
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sel_r <= 1'h0;
        end else begin
            sel_r <= sel_now;
        end
    end

    // write enable toward the head amplifier
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            write_enable <= 1'h0;
        end else begin
            write_enable <= wg_true;
        end
    end

    // write data forced low outside the gate so no stray flux
    // reversal reaches the disk while reading or deselected
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            disk_write_data <= 1'h0;
        end else begin
            disk_write_data <= wg_true && write_data;
        end
    end

    // reduced write current passed on although the drive ignores it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reduced_current <= 1'h0;
        end else begin
            reduced_current <= sel_now && !reduced_wc_n;
        end
    end

    // head number; an unselected drive keeps its last head, and two
    // false lines give head 0
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            head_num <= HEAD_RST;
        end else if (sel_now) begin
            head_num <= ~head_sel_n;
        end
    end

    // seek direction; held while unselected like the head number,
    // since the line only matters at the step trailing edge
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            step_inward <= 1'h0;
        end else if (sel_now) begin
            step_inward <= (dir_in_n == LINE_TRUE);
        end
    end

    // ------------------------------------------------------------
    // step trailing edge detection
    // ------------------------------------------------------------
    // a pulse is armed only while selected and not writing, so a
    // step seen during write gate never moves the actuator
    always_comb begin
        step_st_nxt = step_st_r;
        case (step_st_r)
            STEP_IDLE: begin
                if (sel_now && !wg_true && step_n == LINE_TRUE) begin
                    step_st_nxt = STEP_HIGH;
                end
            end
            STEP_HIGH: begin
                if (!sel_now || wg_true || step_n == LINE_FALSE) begin
                    step_st_nxt = STEP_IDLE;
                end
            end
            default: step_st_nxt = STEP_IDLE;
        endcase
    end

    // step line state, armed only while a step may move the heads
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            step_st_r <= STEP_IDLE;
        end else begin
            step_st_r <= step_st_nxt;
        end
    end

    // fire on true to false only if still selected and reading; a
    // write gate raised while the line is true cancels the step
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            step_pulse <= 1'h0;
        end else begin
            step_pulse <= (step_st_r == STEP_HIGH) && sel_now && !wg_true
                          && step_n == LINE_FALSE;
        end
    end

    // ------------------------------------------------------------
    // outputs toward the host
    // ------------------------------------------------------------
    // read data copied every cycle; only the enable follows select
    // and write gate, so turning the pair around costs one cycle
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            read_data_out  <= 1'h0;
            read_data_oe_n <= 1'h1;
        end else begin
            read_data_out  <= read_data;
            read_data_oe_n <= !(sel_now && !wg_true);
        end
    end

    // status is open collector: the stage only sinks when selected
    // and true, so a false status never fights another drive
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            status_out_n <= LINE_FALSE;
            status_oe_n  <= 1'h1;
        end else begin
            status_out_n <= status_n;
            status_oe_n  <= !(sel_now && status_n == LINE_TRUE);
        end
    end

    // drive selected line: a constant true level gated by the enable
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            drive_selected_n    <= LINE_FALSE;
            drive_selected_oe_n <= 1'h1;
        end else begin
            drive_selected_n    <= LINE_TRUE;
            drive_selected_oe_n <= !sel_now;
        end
    end

    assign selected = sel_r;

endmodule
`default_nettype wire

// *** dv/host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module host_model import drive_ctl_pkg::*; (
    input  wire logic status_out_n,
    input  wire logic status_oe_n,
    input  wire logic read_data_out,
    input  wire logic read_data_oe_n,
    input  wire logic drive_selected_n,
    input  wire logic drive_selected_oe_n,
    output logic      status_line,
    output logic      rd_line,
    output logic      ds_line);
    // pulled-up open-collector lines: a released line reads false
    assign status_line = status_oe_n ? LINE_FALSE : status_out_n;
    assign ds_line = drive_selected_oe_n ? LINE_FALSE : drive_selected_n;
    // radial data pair has no pull: a released pair shows the inverse
    assign rd_line = read_data_oe_n ? !read_data_out : read_data_out;
endmodule
`default_nettype wire

// *** dv/drive_ctl_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module drive_ctl_chk import drive_ctl_pkg::*; (
    input wire logic clk_sys, reset_n, write_gate_n, step_n, selected,
    input wire logic write_enable, step_pulse, read_data_oe_n,
    input wire logic drive_selected_oe_n, input wire logic [1:0] select_id,
    input wire logic [3:0] drive_sel_n);
    wire logic s = !drive_sel_n[select_id]; // strap held steady by bench
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sel_map_a: assert property (
        selected == $past(s)) else $error("sel");
    wr_gate_a: assert property (
        write_enable == $past(s && !write_gate_n)) else $error("wr");
    rd_gate_a: assert property (
        read_data_oe_n == !$past(s && write_gate_n)) else $error("rd");
    step_wr_a: assert property (
        step_pulse |-> $past(s && write_gate_n, 2)) else $error("stw");
    step_edge_a: assert property (
        step_pulse |-> !$past(step_n, 2) && $past(step_n)) else $error("ste");
    step_once_a: assert property (
        step_pulse |=> !step_pulse) else $error("st1");
    idle_open_a: assert property (
        !selected |-> read_data_oe_n && drive_selected_oe_n) else $error("oe");
    idle_quiet_a: assert property (
        !selected |-> !write_enable && !step_pulse) else $error("idle");
endmodule
bind disk_drive_control_select drive_ctl_chk i_drive_ctl_chk (.clk_sys,
    .reset_n, .write_gate_n, .step_n, .selected, .write_enable, .step_pulse,
    .read_data_oe_n, .drive_selected_oe_n, .select_id, .drive_sel_n);
`default_nettype wire

// *** dv/tb_disk_drive_control_select.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_disk_drive_control_select import drive_ctl_pkg::*; ;
    logic clk_sys = 1'h0, reset_n = 1'h0, write_gate_n = 1'h1, step_n = 1'h1;
    logic reduced_wc_n = 1'h1, dir_in_n = 1'h1, status_n = 1'h1, s, oe_n;
    logic write_data = 1'h0, read_data = 1'h0, armed = 1'h0, st_line;
    logic dir = 1'h0, step_inward, read_data_out, rd_oe_n, rd_line;
    logic drive_selected_n, ds_oe_n, ds_line;
    logic [1:0] select_id = 2'h2, head_sel_n = 2'h3, hd = 2'h0, head_num;
    logic [3:0] drive_sel_n = 4'hF;
    logic step_pulse, reduced_current, disk_write_data, status_out_n;
    logic [8:0] q[$], exp_v;
    int n_fail = 0, checks_done = 0;
    wire logic [8:0] act = {step_pulse, head_num, reduced_current,
        disk_write_data, st_line, step_inward, rd_line, ds_line};
    always #4 clk_sys = ~clk_sys;
    disk_drive_control_select i_disk_drive_control_select (.clk_sys,
        .reset_n, .select_id, .drive_sel_n, .reduced_wc_n, .write_gate_n,
        .head_sel_n, .step_n, .dir_in_n, .write_data, .read_data, .status_n,
        .selected(), .write_enable(), .reduced_current, .head_num,
        .step_pulse, .step_inward, .disk_write_data, .read_data_out,
        .read_data_oe_n(rd_oe_n), .status_out_n, .status_oe_n(oe_n),
        .drive_selected_n, .drive_selected_oe_n(ds_oe_n));
    host_model i_host_model (.status_out_n, .status_oe_n(oe_n),
        .read_data_out, .read_data_oe_n(rd_oe_n), .drive_selected_n,
        .drive_selected_oe_n(ds_oe_n), .status_line(st_line),
        .rd_line, .ds_line);
    task automatic conclude();
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog: the run needs about 5000 ns
    initial begin
        #20000 n_fail++;
        conclude();
    end
    // selection held for runs so steps can finish; write gate blocks some
    initial begin
        void'($urandom(60));
        repeat (16) @(posedge clk_sys);
        #2 reset_n = 1'h1;
        repeat (600) begin
            @(posedge clk_sys);
            #2 if ($urandom % 8 == 0)
                drive_sel_n = 4'(~(5'h1 << ($urandom % 5)));
            {reduced_wc_n, head_sel_n, dir_in_n, step_n} = 5'($urandom);
            {write_data, read_data, status_n} = 3'($urandom);
            write_gate_n = ($urandom % 4 != 0);
            s = !drive_sel_n[select_id];
            if (s) {hd, dir} = {~head_sel_n, !dir_in_n};
            q.push_back({armed && s && write_gate_n && step_n, hd,
                s && !reduced_wc_n, s && !write_gate_n && write_data,
                !s || status_n, dir,
                read_data ^ !(s && write_gate_n), !s});
            armed = s && write_gate_n && !step_n;
        end
        // let the last note reach the output comparison
        repeat (2) @(posedge clk_sys);
        conclude();
    end
    // one note per cycle, checked after the edge has settled
    always @(posedge clk_sys) #1 if (q.size() > 0) begin
        exp_v = q.pop_front();
        checks_done++;
        if (act !== exp_v) begin
            n_fail++;
            $display("[ERR] outputs exp %h seen %h", exp_v, act);
        end
    end
endmodule
`default_nettype wire
